/* design/watchdog_reset_control.sv */
// watchdog_reset_control: watchdog, reset cause, boot status, apb registers
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module watchdog_reset_control #(
    parameter int WDOG_TICK_CYCLES = wdog_rst_pkg::WDOG_TICK_CYCLES
) (
    // apb clock and power-on reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    // configuration straps and system events
    input  wire wdog_rst_pkg::boot_cfg_s     boot_cfg,
    input  wire wdog_rst_pkg::reset_events_s rst_events,
    input  wire logic                        send_event_instruction,
    // outputs to the system
    output logic                             system_reset,
    output logic                             irq
);

    // apb decode
    logic       wr_en;
    logic       rd_setup;
    logic       lane0;
    logic [7:0] wbyte;

    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign lane0    = pstrb[0];
    assign wbyte    = pwdata[7:0];

    logic addr_ok;
    always_comb begin
        case (paddr)
            wdog_rst_pkg::OFS_BOOT_CFG,  wdog_rst_pkg::OFS_WDOG_CTRL,
            wdog_rst_pkg::OFS_SCRATCH,   wdog_rst_pkg::OFS_WDOG_CNT,
            wdog_rst_pkg::OFS_UNLOCK,    wdog_rst_pkg::OFS_RST_CAUSE,
            wdog_rst_pkg::OFS_IRQ_STATUS, wdog_rst_pkg::OFS_IRQ_MASK:
                addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    logic wr_ctrl;
    logic wr_scratch;
    logic wr_cnt;
    logic wr_unlock;
    logic wr_status;
    logic wr_mask;
    assign wr_ctrl    = wr_en && lane0 && paddr == wdog_rst_pkg::OFS_WDOG_CTRL;
    assign wr_scratch = wr_en && lane0 && paddr == wdog_rst_pkg::OFS_SCRATCH;
    assign wr_cnt     = wr_en && lane0 && paddr == wdog_rst_pkg::OFS_WDOG_CNT;
    assign wr_unlock  = wr_en && lane0 && paddr == wdog_rst_pkg::OFS_UNLOCK;
    assign wr_status  = wr_en && lane0
                        && paddr == wdog_rst_pkg::OFS_IRQ_STATUS;
    assign wr_mask    = wr_en && lane0 && paddr == wdog_rst_pkg::OFS_IRQ_MASK;

    // safe-access window
    logic       unlocked;
    logic [1:0] unlock_mode;
    logic [3:0] unlock_elapsed;
    logic       unlock_timeout;

    unlock_sequencer u_unlock (
        .pclk     (pclk),
        .presetn  (presetn),
        .sig_wr   (wr_unlock),
        .sig_data (wbyte),
        .unlocked (unlocked),
        .mode     (unlock_mode),
        .elapsed  (unlock_elapsed),
        .timeout  (unlock_timeout)
    );

    // protected bits only take writes while the window is open; a system reset clears them
    logic wr_ctrl_prot;
    assign wr_ctrl_prot = wr_ctrl && unlocked;

    // watchdog prescaler: one-cycle tick every WDOG_TICK_CYCLES clocks
    localparam int PRE_W = $clog2(WDOG_TICK_CYCLES);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(WDOG_TICK_CYCLES - 1);

    logic [PRE_W-1:0] pre_q;
    logic             tick;
    assign tick = (pre_q == PRE_LAST);

    // system reset request, registered below
    logic sys_rst_evt;
    logic wdog_rst_evt;
    logic sw_rst_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else if (tick || sys_rst_evt) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end

    // watchdog counter
    logic [7:0] wdog_cnt_q;
    logic       overflow;
    assign overflow = tick && wdog_cnt_q == wdog_rst_pkg::WDOG_CNT_MAX;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_q <= wdog_rst_pkg::WDOG_CNT_RST;
        end else if (sys_rst_evt) begin
            wdog_cnt_q <= wdog_rst_pkg::WDOG_CNT_RST;
        end else if (wr_cnt) begin
            wdog_cnt_q <= wbyte;
        end else if (tick) begin
            wdog_cnt_q <= wdog_cnt_q + 8'h01;
        end
    end

    // control bits
    logic wdog_flag_q;
    logic irq_en_q;
    logic rst_en_q;
    logic sw_trig_q;

    // an overflow in the same cycle as a clear keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_flag_q <= 1'b0;
        end else if (overflow) begin
            wdog_flag_q <= 1'b1;
        end else if (sys_rst_evt) begin
            wdog_flag_q <= 1'b0;
        end else if ((wr_ctrl && wbyte[wdog_rst_pkg::BIT_WDOG_FLAG])
                     || wr_cnt || send_event_instruction) begin
            wdog_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= 1'b0;
            rst_en_q <= 1'b0;
        end else if (sys_rst_evt) begin
            irq_en_q <= 1'b0;
            rst_en_q <= 1'b0;
        end else if (wr_ctrl_prot) begin
            irq_en_q <= wbyte[wdog_rst_pkg::BIT_WDOG_IRQ_EN];
            rst_en_q <= wbyte[wdog_rst_pkg::BIT_WDOG_RST_EN];
        end
    end

    // software reset bit holds for one cycle then the reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_trig_q <= 1'b0;
        end else if (sys_rst_evt) begin
            sw_trig_q <= 1'b0;
        end else if (wr_ctrl_prot && wbyte[wdog_rst_pkg::BIT_SW_RESET]) begin
            sw_trig_q <= 1'b1;
        end
    end

    // reset sources
    logic manual_evt;
    assign manual_evt   = rst_events.manual_pin
                          && boot_cfg.pin_reset_enabled;
    assign wdog_rst_evt = overflow && rst_en_q;
    assign sw_rst_evt   = sw_trig_q;
    assign sys_rst_evt  = wdog_rst_evt || sw_rst_evt || manual_evt
                          || rst_events.shutdown_wake
                          || rst_events.local_wake;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_reset <= 1'b0;
        end else begin
            system_reset <= sys_rst_evt;
        end
    end

    // last reset cause; only presetn (power-on) returns it to 001
    logic [2:0] cause_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= wdog_rst_pkg::CAUSE_POWER_ON;
        end else if (rst_events.shutdown_wake) begin
            cause_q <= wdog_rst_pkg::CAUSE_SHUTDOWN;
        end else if (rst_events.local_wake) begin
            cause_q <= wdog_rst_pkg::CAUSE_LOCAL | cause_q;
        end else if (manual_evt) begin
            cause_q <= wdog_rst_pkg::CAUSE_MANUAL;
        end else if (wdog_rst_evt) begin
            cause_q <= wdog_rst_pkg::CAUSE_WATCHDOG;
        end else if (sw_rst_evt && !rst_en_q) begin
            cause_q <= wdog_rst_pkg::CAUSE_SOFTWARE;
        end
    end

    // scratch survives every system reset, cleared only by power-on
    logic [7:0] scratch_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_q <= wdog_rst_pkg::SCRATCH_RST;
        end else if (wr_scratch) begin
            scratch_q <= wbyte;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    logic [wdog_rst_pkg::IRQ_BITS-1:0] irq_evt;
    logic [wdog_rst_pkg::IRQ_BITS-1:0] irq_status_q;
    logic [wdog_rst_pkg::IRQ_BITS-1:0] irq_mask_q;

    assign irq_evt[wdog_rst_pkg::BIT_EVT_OVERFLOW]  = overflow;
    assign irq_evt[wdog_rst_pkg::BIT_EVT_UNLOCK_TO] = unlock_timeout;

    genvar gi;
    generate
        for (gi = 0; gi < wdog_rst_pkg::IRQ_BITS; gi++) begin : g_irq
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_status_q[gi] <= 1'b0;
                end else if (irq_evt[gi]) begin
                    irq_status_q[gi] <= 1'b1;
                end else if (wr_status && wbyte[gi]) begin
                    irq_status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= '0;
        end else if (wr_mask) begin
            irq_mask_q <= wbyte[wdog_rst_pkg::IRQ_BITS-1:0];
        end
    end

    // watchdog flag only reaches the line while its enable is set
    assign irq = (wdog_flag_q && irq_en_q)
                 || |(irq_status_q & irq_mask_q);

    // read views
    logic [7:0] cfg_view;
    logic [7:0] ctrl_view;
    logic [7:0] unlock_view;
    always_comb begin
        cfg_view = 8'h00;
        cfg_view[7:6] = wdog_rst_pkg::CFG_TOP_BITS;
        cfg_view[wdog_rst_pkg::BIT_IN_BOOT]    = boot_cfg.in_boot_program;
        cfg_view[wdog_rst_pkg::BIT_DEBUG_EN]   = boot_cfg.debug_port_enabled;
        cfg_view[wdog_rst_pkg::BIT_BOOT_EN]    = boot_cfg.boot_program_enabled;
        cfg_view[wdog_rst_pkg::BIT_PIN_RST_EN] = boot_cfg.pin_reset_enabled;
        cfg_view[wdog_rst_pkg::BIT_ROM_READ]   =
            boot_cfg.flash_external_readable;
        ctrl_view = 8'h00;
        ctrl_view[wdog_rst_pkg::BIT_WDOG_FLAG]   = wdog_flag_q;
        ctrl_view[wdog_rst_pkg::BIT_WDOG_IRQ_EN] = irq_en_q;
        ctrl_view[wdog_rst_pkg::BIT_WDOG_RST_EN] = rst_en_q;
        ctrl_view[wdog_rst_pkg::BIT_SW_RESET]    = sw_trig_q;
        // 3-bit timer view holds the upper bits of the 16-cycle count
        unlock_view = {1'b0, unlock_elapsed[3:1], unlocked, 1'b0, unlock_mode};
    end

    logic [7:0] rd_byte;
    always_comb begin
        case (paddr)
            wdog_rst_pkg::OFS_BOOT_CFG:   rd_byte = cfg_view;
            wdog_rst_pkg::OFS_WDOG_CTRL:  rd_byte = ctrl_view;
            wdog_rst_pkg::OFS_SCRATCH:    rd_byte = scratch_q;
            wdog_rst_pkg::OFS_WDOG_CNT:   rd_byte = wdog_cnt_q;
            wdog_rst_pkg::OFS_UNLOCK:     rd_byte = unlock_view;
            wdog_rst_pkg::OFS_RST_CAUSE:  rd_byte = {5'h00, cause_q};
            wdog_rst_pkg::OFS_IRQ_STATUS: rd_byte = {6'h00, irq_status_q};
            wdog_rst_pkg::OFS_IRQ_MASK:   rd_byte = {6'h00, irq_mask_q};
            default:                      rd_byte = 8'h00;
        endcase
    end

    // read data is captured in the setup cycle so the access needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule // watchdog_reset_control
`default_nettype wire

/* design/wdog_rst_pkg.sv */
// package: register map, field positions, reset values, timing for watchdog/reset block
package wdog_rst_pkg;

    // register byte offsets on apb
    localparam logic [7:0] OFS_BOOT_CFG   = 8'h00;
    localparam logic [7:0] OFS_WDOG_CTRL  = 8'h04;
    localparam logic [7:0] OFS_SCRATCH    = 8'h08;
    localparam logic [7:0] OFS_WDOG_CNT   = 8'h0C;
    localparam logic [7:0] OFS_UNLOCK     = 8'h10;
    localparam logic [7:0] OFS_RST_CAUSE  = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;

    // boot_config_status fields
    localparam int BIT_IN_BOOT    = 5;
    localparam int BIT_DEBUG_EN   = 4;
    localparam int BIT_BOOT_EN    = 3;
    localparam int BIT_PIN_RST_EN = 2;
    localparam int BIT_ROM_READ   = 0;
    localparam logic [1:0] CFG_TOP_BITS = 2'h3;

    // watchdog_reset_control fields
    localparam int BIT_WDOG_FLAG   = 4;
    localparam int BIT_WDOG_IRQ_EN = 2;
    localparam int BIT_WDOG_RST_EN = 1;
    localparam int BIT_SW_RESET    = 0;

    // interrupt status / mask fields
    localparam int BIT_EVT_OVERFLOW = 0;
    localparam int BIT_EVT_UNLOCK_TO = 1;
    localparam int IRQ_BITS = 2;

    // reset cause codes
    localparam logic [2:0] CAUSE_SOFTWARE = 3'h0;
    localparam logic [2:0] CAUSE_POWER_ON = 3'h1;
    localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
    localparam logic [2:0] CAUSE_MANUAL   = 3'h3;
    localparam logic [2:0] CAUSE_SHUTDOWN = 3'h5;
    localparam logic [2:0] CAUSE_LOCAL    = 3'h4;

    // reset values and the watchdog counter top value
    localparam logic [7:0] SCRATCH_RST = 8'h00;
    localparam logic [7:0] WDOG_CNT_RST = 8'h00;
    localparam logic [7:0] WDOG_CNT_MAX = 8'hFF;

    // unlock signature bytes and window length
    localparam logic [7:0] UNLOCK_KEY1 = 8'h57;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hA8;
    localparam int UNLOCK_WINDOW_CYCLES = 16;
    localparam logic [3:0] UNLOCK_LAST = 4'(UNLOCK_WINDOW_CYCLES - 1);

    // watchdog tick period in system clocks
    localparam int WDOG_TICK_CYCLES = 131072;

    // level straps showing boot and protection configuration
    typedef struct packed {
        logic in_boot_program;
        logic debug_port_enabled;
        logic boot_program_enabled;
        logic pin_reset_enabled;
        logic flash_external_readable;
    } boot_cfg_s;

    // one-cycle reset and wake events from outside
    typedef struct packed {
        logic manual_pin;
        logic shutdown_wake;
        logic local_wake;
    } reset_events_s;

endpackage

/* design/unlock_sequencer.sv */
// unlock_sequencer: two-byte signature unlock with a timed write window
`timescale 1ns/10ps
`default_nettype none
module unlock_sequencer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // signature writes
    input  wire logic        sig_wr,
    input  wire logic [7:0]  sig_data,
    // state
    output logic             unlocked,
    output logic [1:0]       mode,
    output logic [3:0]       elapsed,
    output logic             timeout
);

    typedef enum logic [2:0] {
        ST_LOCKED = 3'h1,
        ST_KEY1   = 3'h2,
        ST_OPEN   = 3'h4
    } unlock_state_e;

    unlock_state_e state_q;
    logic [3:0]    timer_q;

    // any value other than the expected key drops straight back to locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_LOCKED;
        end else begin
            case (state_q)
                ST_LOCKED: begin
                    if (sig_wr && sig_data == wdog_rst_pkg::UNLOCK_KEY1) begin
                        state_q <= ST_KEY1;
                    end
                end
                ST_KEY1: begin
                    if (sig_wr) begin
                        state_q <= (sig_data == wdog_rst_pkg::UNLOCK_KEY2)
                                   ? ST_OPEN : ST_LOCKED;
                    end
                end
                ST_OPEN: begin
                    if (sig_wr || timer_q == wdog_rst_pkg::UNLOCK_LAST) begin
                        state_q <= ST_LOCKED;
                    end
                end
                default: state_q <= ST_LOCKED;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_q <= 4'h0;
        end else if (state_q == ST_OPEN) begin
            timer_q <= timer_q + 4'h1;
        end else begin
            timer_q <= 4'h0;
        end
    end

    assign unlocked = (state_q == ST_OPEN);
    assign mode     = (state_q == ST_OPEN) ? 2'h3 :
                      (state_q == ST_KEY1) ? 2'h1 : 2'h0;
    assign elapsed  = timer_q;
    assign timeout  = (state_q == ST_OPEN) && !sig_wr
                      && (timer_q == wdog_rst_pkg::UNLOCK_LAST);

endmodule // unlock_sequencer
`default_nettype wire

/* tb/wdog_rst_properties.sv */
// checker: port-level properties of the watchdog and reset-control block
`timescale 1ns/10ps
`default_nettype none
module wdog_rst_checker #(
    parameter int WDOG_TICK_CYCLES = 16
) (
    // apb side
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [7:0]                  paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic                        pready,
    input wire logic [31:0]                 prdata,
    input wire logic                        pslverr,
    // system side
    input wire wdog_rst_pkg::boot_cfg_s     boot_cfg,
    input wire wdog_rst_pkg::reset_events_s rst_events,
    input wire logic                        send_event_instruction,
    input wire logic                        system_reset,
    input wire logic                        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc;
    logic       mapped;
    logic [4:0] cfg;
    logic [7:0] scratch_q;
    assign acc = psel && penable;
    assign mapped = paddr <= wdog_rst_pkg::OFS_IRQ_MASK && paddr[1:0] == 2'h0;
    assign cfg = boot_cfg;
    // mirror of the keep byte: only apb writes may move it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_q <= 8'h00;
        end else if (acc && pwrite && pstrb[0]
                     && paddr == wdog_rst_pkg::OFS_SCRATCH) begin
            scratch_q <= pwdata[7:0];
        end
    end
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_err_unmapped; acc && !mapped |-> pslverr; endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("no error on unmapped address");
    property p_err_mapped; acc && mapped |-> !pslverr; endproperty
    a_err_mapped: assert property (p_err_mapped)
        else $error("error on mapped address");
    property p_cfg_read;
        acc && !pwrite && paddr == wdog_rst_pkg::OFS_BOOT_CFG |->
            prdata[7:0] == {2'h3, $past(cfg[4:1]), 1'b0, $past(cfg[0])};
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("configuration status mismatch");
    property p_keep_read;
        acc && !pwrite && paddr == wdog_rst_pkg::OFS_SCRATCH |->
            prdata[7:0] == scratch_q;
    endproperty
    a_keep_read: assert property (p_keep_read)
        else $error("keep byte lost its value");
    property p_reset_pulse; system_reset && rst_events == 3'h0 |=> !system_reset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("system reset longer than one cycle");
    property p_event_reset;
        rst_events.shutdown_wake || rst_events.local_wake
            || (rst_events.manual_pin && boot_cfg.pin_reset_enabled)
            |=> system_reset;
    endproperty
    a_event_reset: assert property (p_event_reset)
        else $error("reset event gave no system reset");
    property p_quiet; $rose(presetn) |-> !irq && !system_reset; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs active after reset");
endmodule // wdog_rst_checker

bind watchdog_reset_control wdog_rst_checker #(
    .WDOG_TICK_CYCLES(WDOG_TICK_CYCLES)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .boot_cfg(boot_cfg), .rst_events(rst_events),
    .send_event_instruction(send_event_instruction),
    .system_reset(system_reset), .irq(irq)
);
`default_nettype wire

/* tb/testbench.sv */
// testbench: register-level tests of the watchdog and reset-control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [7:0] A_CFG = wdog_rst_pkg::OFS_BOOT_CFG;
    localparam logic [7:0] A_CTRL = wdog_rst_pkg::OFS_WDOG_CTRL;
    localparam logic [7:0] A_KEEP = wdog_rst_pkg::OFS_SCRATCH;
    localparam logic [7:0] A_CNT = wdog_rst_pkg::OFS_WDOG_CNT;
    localparam logic [7:0] A_KEY = wdog_rst_pkg::OFS_UNLOCK;
    localparam logic [7:0] A_CAUSE = wdog_rst_pkg::OFS_RST_CAUSE;
    localparam logic [7:0] A_STAT = wdog_rst_pkg::OFS_IRQ_STATUS;
    localparam logic [7:0] A_MASK = wdog_rst_pkg::OFS_IRQ_MASK;
    logic                        pclk;
    logic                        presetn;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [7:0]                  paddr;
    logic [31:0]                 pwdata;
    logic [3:0]                  pstrb;
    logic                        pready;
    logic [31:0]                 prdata;
    logic                        pslverr;
    wdog_rst_pkg::boot_cfg_s     boot_cfg;
    wdog_rst_pkg::reset_events_s rst_events;
    logic                        send_event_instruction;
    logic                        system_reset;
    logic                        irq;
    logic [7:0]                  q;
    logic                        err;
    logic [4:0]                  pat [3] = '{5'h15, 5'h0A, 5'h1F};
    int                          i;
    int                          errors;
    int                          tests_run;

    watchdog_reset_control #(.WDOG_TICK_CYCLES(16)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .boot_cfg(boot_cfg), .rst_events(rst_events),
        .send_event_instruction(send_event_instruction),
        .system_reset(system_reset), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic unlock();
        wr(A_KEY, 8'h57);
        wr(A_KEY, 8'hA8);
    endtask

    // bounded wait on irq or system_reset, sampled mid-cycle
    task automatic wait_for(input logic want_irq);
        int n;
        n = 0;
        @(negedge pclk);
        while ((want_irq ? irq : system_reset) !== 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
        end
        chk({7'h00, want_irq ? irq : system_reset}, 8'h01);
    endtask

    task automatic pin(input logic v);
        @(negedge pclk);
        chk({7'h00, irq}, {7'h00, v});
    endtask

    task automatic fire(input logic [2:0] e, input logic [2:0] cause);
        @(posedge pclk);
        rst_events <= e;
        @(posedge pclk);
        rst_events <= 3'h0;
        wait_for(1'b0);
        rd(A_CAUSE, {5'h00, cause});
    endtask

    task automatic conclude();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #40000;
        errors++;
        conclude();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        boot_cfg = 5'h1F;
        rst_events = 3'h0;
        send_event_instruction = 1'b0;
        errors = 0;
        tests_run = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CAUSE, 8'h01);
        rd(A_KEEP, 8'h00);
        rd(A_CTRL, 8'h00);
        for (i = 0; i < 3; i++) begin
            boot_cfg <= pat[i];
            rd(A_CFG, {2'h3, pat[i][4:1], 1'b0, pat[i][0]});
        end
        apb(1'b0, 8'h20, 8'h00);
        chk({7'h00, err}, 8'h01);
        chk(q, 8'h00);
        wr(A_KEEP, 8'hA5);
        pstrb <= 4'h0;
        wr(A_KEEP, 8'h3C);
        pstrb <= 4'hF;
        rd(A_KEEP, 8'hA5);
        // manual pin while the pin reset is disabled must change nothing
        boot_cfg <= 5'h1D;
        @(posedge pclk);
        rst_events <= 3'h4;
        @(posedge pclk);
        rst_events <= 3'h0;
        rd(A_CAUSE, 8'h01);
        boot_cfg <= 5'h1F;
        fire(3'h4, 3'h3);
        unlock();
        wr(A_CTRL, 8'h02);
        wr(A_CTRL, 8'h03);
        wait_for(1'b0);
        rd(A_CAUSE, 8'h03);
        fire(3'h1, 3'h7);
        unlock();
        wr(A_CTRL, 8'h01);
        wait_for(1'b0);
        rd(A_CAUSE, 8'h00);
        rd(A_CTRL, 8'h00);
        fire(3'h1, 3'h4);
        unlock();
        wr(A_CTRL, 8'h02);
        wr(A_KEY, 8'h00);
        wr(A_CNT, 8'hFF);
        wait_for(1'b0);
        rd(A_CAUSE, 8'h02);
        // the overflow that caused the reset leaves its flag standing
        rd(A_CTRL, 8'h10);
        fire(3'h1, 3'h6);
        fire(3'h2, 3'h5);
        wr(A_CTRL, 8'h04);
        rd(A_CTRL, 8'h00);
        unlock();
        wr(A_CTRL, 8'h04);
        wr(A_KEY, 8'h00);
        for (i = 0; i < 3; i++) begin
            wr(A_CNT, 8'hFF);
            wait_for(1'b1);
            rd(A_CTRL, 8'h14);
            if (i == 0) begin
                wr(A_CTRL, 8'h10);
            end else if (i == 1) begin
                wr(A_CNT, 8'h00);
            end else begin
                @(posedge pclk);
                send_event_instruction <= 1'b1;
                @(posedge pclk);
                send_event_instruction <= 1'b0;
            end
            pin(1'b0);
            rd(A_CTRL, 8'h04);
        end
        unlock();
        wr(A_CTRL, 8'h00);
        wr(A_KEY, 8'h00);
        wr(A_CNT, 8'hFF);
        // the next tick wraps FF to 00 with reset and irq enable off
        repeat (40) @(posedge pclk);
        pin(1'b0);
        rd(A_CTRL, 8'h10);
        wr(A_MASK, 8'h01);
        pin(1'b1);
        // bit 1 comes from the earlier unlock windows left to time out
        rd(A_STAT, 8'h03);
        wr(A_STAT, 8'h03);
        pin(1'b0);
        rd(A_STAT, 8'h00);
        rd(A_KEEP, 8'hA5);
        conclude();
    end
endmodule // testbench
`default_nettype wire
